//--- emma_defines.svh
// constants of the exponent / min-max / modify-decrement datapath slice
// assumes a single 100 MHz core clock and an AHB-Lite register bus
// Overview of operation
// - exponent equals leading sign bit count minus one
// - exponent adjust writes the smallest of sample exponents and reference
// - reference and result are unsigned 16-bit values in a low half
// - exponents range 0 to 31; 31 for 32-bit, 15 for 16-bit samples
// - samples are a full word, one half, or both halves together
// - zero and minus one samples yield the largest exponent, 31 or 15
// - exponent adjust touches only the destination low half and, of the flags, only clears reject
// - maximum writes the more positive of two signed words
// - minimum writes the source closest to negative infinity
// - max and min set zero and negative, clear overflow and reject, keep the rest
// - accumulator decrement saturates to 40 bits by default
// - with the 32-bit option it saturates to 32 bits, sign extended
// - pointer and index decrements write the plain difference; of the flags they only clear reject
// - accumulator decrement sets zero, negative and carry flags
// - overflow flag follows overflow; its sticky copy is only ever set
// - pointer/index forms are 16-bit, accumulator forms 32-bit
// - eight data, eight pointer, four index and four modify registers
// - 16-bit decrement forms are refused inside a parallel group
// - 32-bit forms may issue within a parallel group
`ifndef EMMA_DEFINES_SVH
`define EMMA_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define EMMA_OFF_CMD     8'h00
`define EMMA_OFF_FLAGS   8'h04
`define EMMA_OFF_A0_LO   8'h08
`define EMMA_OFF_A0_HI   8'h0c
`define EMMA_OFF_A1_LO   8'h10
`define EMMA_OFF_A1_HI   8'h14
`define EMMA_OFF_DREG    8'h40
`define EMMA_OFF_PREG    8'h60
`define EMMA_OFF_IREG    8'h80
`define EMMA_OFF_MREG    8'h90

// ------------------------------------------------------------
// flag bit positions and reset value
// ------------------------------------------------------------
`define EMMA_FLG_ZERO    0
`define EMMA_FLG_NEG     1
`define EMMA_FLG_CARRY   2
`define EMMA_FLG_AOVF    3
`define EMMA_FLG_ASTICKY 4
`define EMMA_FLG_OVF     5
`define EMMA_FLG_REJECT  6
`define EMMA_FLG_W       7
`define EMMA_FLG_RESET   7'h00

// ------------------------------------------------------------
// sample forms
// ------------------------------------------------------------
`define EMMA_FORM_WORD   2'h0
`define EMMA_FORM_HALF   2'h1
`define EMMA_FORM_BOTH   2'h2

`endif

//--- emma_pkg.sv
// types of the exponent / min-max / modify-decrement datapath slice
// assumes emma_defines.svh for offsets, flag positions and forms; op codes are set here
package emma_pkg;

    // operation codes carried in the command word
    typedef enum logic [3:0] {
        EMMA_OP_NONE   = 4'h0,
        EMMA_OP_EXPADJ = 4'h1,
        EMMA_OP_MAX    = 4'h2,
        EMMA_OP_MIN    = 4'h3,
        EMMA_OP_ADEC   = 4'h4,
        EMMA_OP_PDEC   = 4'h5,
        EMMA_OP_IDEC   = 4'h6
    } emma_op_e;

    // command word, high bit first
    typedef struct packed {
        logic [12:0] spare;
        logic        len32;
        logic        parallel;
        logic        half_hi;
        logic [1:0]  form;
        logic        sat32;
        logic [2:0]  src1;
        logic [2:0]  src0;
        logic [2:0]  dest;
        emma_op_e    op;
    } emma_cmd_s;

    // arithmetic status
    typedef struct packed {
        logic reject;
        logic ovf;
        logic acc_zero_overflow_sticky;
        logic acc_zero_overflow_flag;
        logic carry_out_flag;
        logic negative_result_flag;
        logic zero_result_flag;
    } emma_flags_s;

endpackage

//--- emma_alu.sv
// exponent adjust, max, min and modify-decrement slice with its register file
// assumes an AHB-Lite master issuing single word transfers; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "emma_defines.svh"

module emma_alu
    import emma_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int NUM_D  = 8,
    parameter int NUM_P  = 8,
    parameter int NUM_IM = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DATA_W != 32 || NUM_D != 8 || NUM_P != 8 || NUM_IM != 4) begin : g_chk
        $error("emma_alu: register set dimensions are fixed");
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0] dreg_q [NUM_D];
    logic [31:0] preg_q [NUM_P];
    logic [31:0] ireg_q [NUM_IM];
    logic [31:0] mreg_q [NUM_IM];
    logic [39:0] acc0_q;
    logic [39:0] acc1_q;
    emma_flags_s flags_q;

    // ------------------------------------------------------------
    // bus address and data phase
    // ------------------------------------------------------------
    logic        dp_valid_q;
    logic        dp_write_q;
    logic [7:0]  dp_addr_q;
    logic        rd_wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;

    wire addr_take = hsel & hready & htrans[1];
    wire wr_now    = dp_valid_q & dp_write_q;
    wire rd_now    = dp_valid_q & ~dp_write_q;

    assign hreadyout = ~(rd_now & ~rd_wait_q);
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
        end else if (hreadyout) begin
            dp_valid_q <= addr_take;
            dp_write_q <= hwrite;
            dp_addr_q  <= haddr[7:0];
        end
    end

    // reads take one wait state so that data comes from a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_wait_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            rd_wait_q <= rd_now & ~rd_wait_q;
            if (rd_now & ~rd_wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire [2:0] sel8 = dp_addr_q[4:2];
    wire [1:0] sel4 = dp_addr_q[3:2];
    wire hit_cmd   = dp_addr_q == `EMMA_OFF_CMD;
    wire hit_flags = dp_addr_q == `EMMA_OFF_FLAGS;
    wire hit_a0lo  = dp_addr_q == `EMMA_OFF_A0_LO;
    wire hit_a0hi  = dp_addr_q == `EMMA_OFF_A0_HI;
    wire hit_a1lo  = dp_addr_q == `EMMA_OFF_A1_LO;
    wire hit_a1hi  = dp_addr_q == `EMMA_OFF_A1_HI;
    wire hit_d     = dp_addr_q[7:5] == `EMMA_OFF_DREG >> 5;
    wire hit_p     = dp_addr_q[7:5] == `EMMA_OFF_PREG >> 5;
    wire hit_i     = dp_addr_q[7:4] == `EMMA_OFF_IREG >> 4;
    wire hit_m     = dp_addr_q[7:4] == `EMMA_OFF_MREG >> 4;

    assign rd_mux = hit_flags ? {25'h0, flags_q} :
                    hit_a0lo  ? acc0_q[31:0] :
                    hit_a0hi  ? {24'h0, acc0_q[39:32]} :
                    hit_a1lo  ? acc1_q[31:0] :
                    hit_a1hi  ? {24'h0, acc1_q[39:32]} :
                    hit_d     ? dreg_q[sel8] :
                    hit_p     ? preg_q[sel8] :
                    hit_i     ? ireg_q[sel4] :
                    hit_m     ? mreg_q[sel4] : 32'h0000_0000;

    // ------------------------------------------------------------
    // command decode and issue legality
    // ------------------------------------------------------------
    emma_cmd_s cmd;
    assign cmd = hwdata;

    wire cmd_go   = wr_now & hit_cmd;
    wire is_short = cmd.op == EMMA_OP_PDEC || cmd.op == EMMA_OP_IDEC;
    wire is_long  = cmd.op == EMMA_OP_EXPADJ || cmd.op == EMMA_OP_MAX ||
                    cmd.op == EMMA_OP_MIN || cmd.op == EMMA_OP_ADEC;
    wire bad_form = cmd.op == EMMA_OP_EXPADJ && cmd.form == 2'h3;
    // short forms only as 16-bit, never grouped; long forms 32-bit, may group
    wire legal    = (is_short & ~cmd.len32 & ~cmd.parallel)
                  | (is_long & cmd.len32 & ~bad_form);
    wire exec     = cmd_go & legal;

    wire [31:0] src0 = dreg_q[cmd.src0];
    wire [31:0] src1 = dreg_q[cmd.src1];

    // ------------------------------------------------------------
    // exponent adjust
    // ------------------------------------------------------------
    // redundant sign bits of a word; a half is padded with an inverted
    // sign bit below it so the count stops at 15
    function automatic logic [4:0] exp_of(input logic [31:0] v);
        logic [4:0] n;
        logic       run;
        n   = 5'h00;
        run = 1'b1;
        for (int i = 30; i >= 0; i--) begin
            if (run && v[i] == v[31]) begin
                n = n + 5'h01;
            end else begin
                run = 1'b0;
            end
        end
        return n;
    endfunction

    wire [15:0] ref_exp = dreg_q[cmd.src1][15:0];
    wire [15:0] lo_half = src0[15:0];
    wire [15:0] hi_half = src0[31:16];
    wire [15:0] one_half = cmd.half_hi ? hi_half : lo_half;
    wire [4:0]  e_word = exp_of(src0);
    wire [4:0]  e_lo   = exp_of({lo_half, ~lo_half[15], 15'h0000});
    wire [4:0]  e_hi   = exp_of({hi_half, ~hi_half[15], 15'h0000});
    wire [4:0]  e_one  = exp_of({one_half, ~one_half[15], 15'h0000});
    wire [4:0]  e_both = (e_lo < e_hi) ? e_lo : e_hi;
    wire [4:0]  e_samp = cmd.form == `EMMA_FORM_WORD ? e_word :
                         cmd.form == `EMMA_FORM_HALF ? e_one : e_both;
    wire [15:0] e_ext  = {11'h000, e_samp};
    wire [15:0] exp_res = (e_ext < ref_exp) ? e_ext : ref_exp;

    // ------------------------------------------------------------
    // maximum and minimum
    // ------------------------------------------------------------
    // signed compare equals the sign and flag test of src0 - src1
    wire        s0_lt = $signed(src0) < $signed(src1);
    wire [31:0] max_res = s0_lt ? src1 : src0;
    wire [31:0] min_res = s0_lt ? src0 : src1;
    wire [31:0] mm_res  = cmd.op == EMMA_OP_MAX ? max_res : min_res;

    // ------------------------------------------------------------
    // accumulator decrement
    // ------------------------------------------------------------
    wire [40:0] acc_true = {acc0_q[39], acc0_q} - {acc1_q[39], acc1_q};
    wire [40:0] acc_cy   = {1'b0, acc0_q} + {1'b0, ~acc1_q} + 41'h001;
    wire        ovf40    = acc_true[40] != acc_true[39];
    wire        ovf32    = ~(&acc_true[40:31] | ~|acc_true[40:31]);
    wire [39:0] sat40    = acc_true[40] ? 40'h80_0000_0000 : 40'h7f_ffff_ffff;
    wire [39:0] sat32    = acc_true[40] ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
    wire        acc_ovf  = cmd.sat32 ? ovf32 : ovf40;
    wire [39:0] acc_res  = cmd.sat32 ? (ovf32 ? sat32 : {{8{acc_true[31]}}, acc_true[31:0]})
                                     : (ovf40 ? sat40 : acc_true[39:0]);

    // ------------------------------------------------------------
    // pointer and index decrement
    // ------------------------------------------------------------
    wire [1:0]  idx_d   = cmd.dest[1:0];
    wire [1:0]  idx_s   = cmd.src0[1:0];
    wire [31:0] p_res   = preg_q[cmd.dest] - preg_q[cmd.src0];
    wire [31:0] i_res   = ireg_q[idx_d] - mreg_q[idx_s];

    // ------------------------------------------------------------
    // write enables
    // ------------------------------------------------------------
    wire do_exp  = exec & cmd.op == EMMA_OP_EXPADJ;
    wire do_mm   = exec & (cmd.op == EMMA_OP_MAX || cmd.op == EMMA_OP_MIN);
    wire do_acc  = exec & cmd.op == EMMA_OP_ADEC;
    wire do_p    = exec & cmd.op == EMMA_OP_PDEC;
    wire do_i    = exec & cmd.op == EMMA_OP_IDEC;
    wire bus_d   = wr_now & hit_d;
    wire bus_p   = wr_now & hit_p;
    wire bus_i   = wr_now & hit_i;
    wire bus_m   = wr_now & hit_m;

    // ------------------------------------------------------------
    // register file update
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int k = 0; k < NUM_D; k++) begin
                dreg_q[k] <= 32'h0000_0000;
                preg_q[k] <= 32'h0000_0000;
            end
            for (int k = 0; k < NUM_IM; k++) begin
                ireg_q[k] <= 32'h0000_0000;
                mreg_q[k] <= 32'h0000_0000;
            end
        end else begin
            if (bus_d) begin
                dreg_q[sel8] <= hwdata;
            end
            if (do_exp) begin
                dreg_q[cmd.dest][15:0] <= exp_res;
            end
            if (do_mm) begin
                dreg_q[cmd.dest] <= mm_res;
            end
            if (bus_p) begin
                preg_q[sel8] <= hwdata;
            end
            if (do_p) begin
                preg_q[cmd.dest] <= p_res;
            end
            if (bus_i) begin
                ireg_q[sel4] <= hwdata;
            end
            if (do_i) begin
                ireg_q[idx_d] <= i_res;
            end
            if (bus_m) begin
                mreg_q[sel4] <= hwdata;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc0_q <= 40'h00_0000_0000;
            acc1_q <= 40'h00_0000_0000;
        end else begin
            if (wr_now & hit_a0lo) begin
                acc0_q[31:0] <= hwdata;
            end
            if (wr_now & hit_a0hi) begin
                acc0_q[39:32] <= hwdata[7:0];
            end
            if (wr_now & hit_a1lo) begin
                acc1_q[31:0] <= hwdata;
            end
            if (wr_now & hit_a1hi) begin
                acc1_q[39:32] <= hwdata[7:0];
            end
            if (do_acc) begin
                acc0_q <= acc_res;
            end
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    emma_flags_s flags_d;
    always_comb begin
        flags_d = flags_q;
        if (wr_now & hit_flags) begin
            flags_d = hwdata[`EMMA_FLG_W-1:0];
        end
        if (cmd_go) begin
            flags_d.reject = ~legal;
        end
        if (do_mm) begin
            flags_d.zero_result_flag     = mm_res == 32'h0000_0000;
            flags_d.negative_result_flag = mm_res[31];
            flags_d.ovf                  = 1'b0;
        end
        if (do_acc) begin
            flags_d.zero_result_flag       = acc_res == 40'h00_0000_0000;
            flags_d.negative_result_flag   = acc_res[39];
            flags_d.carry_out_flag         = acc_cy[40];
            flags_d.acc_zero_overflow_flag = acc_ovf;
            if (acc_ovf) begin
                flags_d.acc_zero_overflow_sticky = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= `EMMA_FLG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule
`default_nettype wire

//--- emma_ahb_master.sv
// ahb-lite master model issuing single word transfers for the bench
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
`default_nettype none
module emma_ahb_master (
    // clock
    input  wire logic        clk,
    // bus
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    logic tmo;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tmo = 1'b0;
    end
    // -----------------------------------------------
    // bounded wait for hready at a rising edge
    // -----------------------------------------------
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) tmo = 1'b1;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        // released data bus shows a changed value
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

//--- emma_alu_assertions.sv
// bus timing checks on the ports of emma_alu
// assumes hready is tied to hreadyout and one clock domain
`timescale 1ns/1ps
`default_nettype none
module emma_alu_assertions (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // ahb-lite slave
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
    wire logic wr_take = hsel && hready && htrans[1] && hwrite;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_rd_wait; rd_take |=> !hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read lacks wait");
    property p_rd_answer; !hreadyout |=> hreadyout; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("wait too long");
    property p_wr_fast; wr_take |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_wait_cause; !hreadyout |-> $past(rd_take); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("stray wait");
    property p_rdata_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
    property p_rdata_reset; $rose(reset_n) |-> hrdata == 32'h0; endproperty
    a_rdata_reset: assert property (p_rdata_reset) else $error("hrdata not reset");
    property p_wr_keep; wr_take |=> $stable(hrdata) [*2]; endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("write moved hrdata");
    c_read: cover property (rd_take);
    c_cmd: cover property (wr_take && haddr[7:0] == 8'h00);
    c_wait: cover property (!hreadyout ##1 hreadyout);
endmodule
bind emma_alu emma_alu_assertions u_chk (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
);
`default_nettype wire

//--- exponent_minmax_modify_alu_bench.sv
// self-checking bench: commands written over the bus, results read back
// assumes emma_alu, emma_ahb_master and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "emma_defines.svh"
module exponent_minmax_modify_alu_bench
    import emma_pkg::*;
;
    localparam logic [31:0] XS [12] = '{32'h52, 32'hffff0052, 32'h52, 32'hf0000052,
        32'h765, 32'hc765, 32'h07650000, 32'hff740765, 32'he7220765, 32'h0,
        32'hffffffff, 32'h00010000};
    localparam logic [15:0] XR [12] = '{12, 12, 27, 27, 12, 12, 12, 12, 12, 31, 20, 20};
    localparam logic [2:0]  XF [12] = '{0, 0, 0, 0, 1, 1, 5, 2, 2, 0, 5, 2};
    localparam logic [15:0] XE [12] = '{12, 12, 24, 3, 4, 1, 4, 4, 2, 31, 15, 14};
    localparam logic [31:0] MA [5] = '{0, 32'h80000000, 32'hffffffff, 32'h7fffffff, 0};
    localparam logic [31:0] MB [5] = '{32'hf, 32'hf, 32'hf, 32'h80000000, 32'hffffffff};
    localparam logic [39:0] A0 [7] = '{5, 3, 5, 40'h7fffffffff, 40'h8000000000,
        40'h7fffffff, 40'h10};
    localparam logic [39:0] A1 [7] = '{3, 5, 5, 40'hffffffffff, 1, 40'hffffffffff, 40'h20};
    localparam logic        AW [7] = '{0, 0, 0, 0, 0, 1, 1};
    localparam logic [31:0] BAD [6] = '{32'h40375, 32'h20375, 32'h20116, 32'h40007,
        32'h4c071, 32'h4};
    logic               clk;
    logic               reset_n;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    logic [31:0]        q;
    logic [31:0]        a;
    logic [31:0]        b;
    logic [31:0]        r;
    logic signed [40:0] df;
    logic signed [40:0] hi;
    logic signed [40:0] lo;
    logic [39:0]        e;
    logic               ov;
    logic               cy;
    logic               st;
    int                 error_cnt;
    int                 check_count;
    emma_alu dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    emma_ahb_master m (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // -----------------------------------------------
    // bus access and compare helpers
    // -----------------------------------------------
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        m.xfer(w, ad, d, q);
        if (m.tmo === 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t bus timeout", $time);
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x);
        bus(1'b0, ad, 32'h0);
        check_count++;
        if (q !== x) begin
            error_cnt++;
            $display("[ERR] %0t addr %h got %h exp %h", $time, ad, q, x);
        end
    endtask
    task automatic cmd(emma_op_e op, logic [2:0] d, s0, s1, logic sat, logic [1:0] f,
                       logic h, par, l32);
        wr(`EMMA_OFF_CMD, emma_cmd_s'{13'h0, l32, par, h, f, sat, s1, s0, d, op});
    endtask
    initial begin
        reset_n = 1'b0;
        error_cnt = 0;
        check_count = 0;
        st = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(`EMMA_OFF_FLAGS, 32'h0);
        rd(`EMMA_OFF_A0_HI, 32'h0);
        wr(8'h20, 32'hdeadbeef);
        rd(8'h20, 32'h0);
        for (int i = 0; i < 12; i++) begin
            wr(8'h50, XS[i]);
            wr(8'h48, {16'h5a5a, XR[i]});
            wr(8'h54, 32'habcd0000);
            wr(`EMMA_OFF_FLAGS, 32'h3f);
            cmd(EMMA_OP_EXPADJ, 3'h5, 3'h4, 3'h2, 1'b0, XF[i][1:0], XF[i][2], 1'b0, 1'b1);
            rd(8'h54, {16'habcd, XE[i]});
            rd(`EMMA_OFF_FLAGS, 32'h3f);
        end
        cmd(EMMA_OP_EXPADJ, 3'h2, 3'h4, 3'h2, 1'b0, 2'h2, 1'b0, 1'b1, 1'b1);
        rd(8'h48, {16'h5a5a, 16'd14});
        for (int i = 0; i < 10; i++) begin
            a = MA[i % 5];
            b = MB[i % 5];
            r = ((i < 5) == ($signed(a) > $signed(b))) ? a : b;
            wr(8'h40, a);
            wr(8'h44, b);
            wr(`EMMA_OFF_FLAGS, 32'h3c);
            cmd(i < 5 ? EMMA_OP_MAX : EMMA_OP_MIN, 3'h3, 3'h0, 3'h1, 1'b0, 2'h0, 1'b0,
                1'b0, 1'b1);
            rd(8'h4c, r);
            rd(`EMMA_OFF_FLAGS, {27'h7, r[31], r == 32'h0});
        end
        wr(`EMMA_OFF_FLAGS, 32'h0);
        for (int i = 0; i < 7; i++) begin
            df = $signed({A0[i][39], A0[i]}) - $signed({A1[i][39], A1[i]});
            cy = A0[i] >= A1[i];
            hi = AW[i] ? 41'sh007fffffff : 41'sh7fffffffff;
            lo = ~hi;
            ov = df > hi || df < lo;
            e = (df > hi) ? hi[39:0] : (df < lo) ? lo[39:0] : df[39:0];
            st = st | ov;
            wr(`EMMA_OFF_A0_LO, A0[i][31:0]);
            wr(`EMMA_OFF_A0_HI, {24'h0, A0[i][39:32]});
            wr(`EMMA_OFF_A1_LO, A1[i][31:0]);
            wr(`EMMA_OFF_A1_HI, {24'h0, A1[i][39:32]});
            cmd(EMMA_OP_ADEC, 3'h0, 3'h0, 3'h0, AW[i], 2'h0, 1'b0, i[0], 1'b1);
            rd(`EMMA_OFF_A0_LO, e[31:0]);
            rd(`EMMA_OFF_A0_HI, {24'h0, e[39:32]});
            rd(`EMMA_OFF_FLAGS, {27'h0, st, ov, cy, e[39], e == 40'h0});
        end
        wr(8'h7c, 32'h0);
        wr(8'h78, 32'h1);
        wr(8'h84, 32'h20);
        wr(8'h98, 32'h28);
        wr(`EMMA_OFF_FLAGS, 32'h7f);
        cmd(EMMA_OP_PDEC, 3'h7, 3'h6, 3'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        rd(8'h7c, 32'hffffffff);
        cmd(EMMA_OP_IDEC, 3'h1, 3'h2, 3'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        rd(8'h84, 32'hfffffff8);
        rd(`EMMA_OFF_FLAGS, 32'h3f);
        // refused encodings keep every register and raise only the reject flag
        for (int i = 0; i < 6; i++) begin
            wr(`EMMA_OFF_CMD, BAD[i]);
            rd(`EMMA_OFF_FLAGS, 32'h7f);
            rd(8'h7c, 32'hffffffff);
        end
        rd(`EMMA_OFF_CMD, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
